// >>> inc/touch_key_pkg.sv
package touch_key_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] idx_time_slot_timer = 8'h00;
    localparam logic [7:0] idx_touch_control = 8'h01;
    localparam logic [7:0] idx_touch_osc_frequency = 8'h02;
    localparam logic [7:0] idx_reference_count_low = 8'h03;
    localparam logic [7:0] idx_reference_count_high = 8'h04;
    localparam logic [7:0] idx_module_base = 8'h08;
    localparam logic [7:0] idx_module_stride = 8'h08;
    localparam logic [2:0] sub_cf_count_low = 3'h0;
    localparam logic [2:0] sub_cf_count_high = 3'h1;
    localparam logic [2:0] sub_ref_capacitor_low = 3'h2;
    localparam logic [2:0] sub_ref_capacitor_high = 3'h3;
    localparam logic [2:0] sub_control_mux_freq = 3'h4;
    localparam logic [2:0] sub_control_osc_pins = 3'h5;

    // Field positions in touch_control
    localparam int bit_slot_ovf = 6;
    localparam int bit_start = 5;
    localparam int bit_cf_ovf = 4;
    localparam int bit_ref_ovf = 3;
    localparam int bit_shared_slot = 2;
    localparam logic [7:0] touch_control_mask = 8'h7f;
    localparam logic [7:0] touch_osc_frequency_mask = 8'h03;
    localparam logic [7:0] ref_capacitor_high_mask = 8'h03;
    localparam logic [7:0] control_osc_pins_mask = 8'hbf;

    // Fields in module_control_osc_pins
    localparam int bit_slot_clock_select = 7;
    localparam int bit_reference_osc_enable = 5;
    localparam int bit_key_osc_enable = 4;

    // Slot period = (slot_base - timer) * slot_prescale slot clocks
    localparam int slot_base = 256;
    localparam int slot_prescale = 32;
    localparam int slot_prescale_bits = 5;
    localparam logic [1:0] slot_sysclk_div = 2'h3;

    localparam logic [15:0] count_max = 16'hffff;
    localparam logic [7:0] reset_byte = 8'h00;

    typedef struct packed {
        logic [7:0] cf_count_low;
        logic [7:0] cf_count_high;
        logic [7:0] ref_capacitor_low;
        logic [7:0] ref_capacitor_high;
        logic [7:0] control_mux_freq;
        logic [7:0] control_osc_pins;
    } module_regs_t;

    typedef struct packed {
        logic [slot_prescale_bits-1:0] prescale;
        logic [7:0] timer;
        logic [15:0] cf_count;
        logic [1:0] key_sync1;
        logic [1:0] key_sync2;
        logic [1:0] key_prev;
    } module_meas_t;

endpackage

// >>> logic/touch_key_measure.sv
// Contract
// - Slot period is (256 - timer) times 32
// - Slot overflow sets flag, interrupt, stops oscillators
// - Slot overflow switches off all counters
// - Start low clears counters, keeps timer register
// - Start rising edge opens measurement counters
// - Any C/F overflow sets sticky flag bit4
// - Reference overflow sets sticky flag bit3
// - Shared select uses module 0 slot counter
// - Reference clock is sysclk div 1,2,4,8
// - Oscillator frequency field selects 500..2000 kHz
// - Ten-bit reference capacitor split low/high
// - Mux field picks key one to four
// - Multi-frequency enable in bit 5
// - Filter enable in bit 4
// - Hopping bit picks hardware or software frequency
// - Software frequency field eight steps 1380..2740
// - Counts read-only bytes, reset to zero
// - Unimplemented bits read zero, ignore writes
// - One register set per module
// - Slot clock from reference osc or sysclk/4
// - Separate reference and key oscillator enables
// - Pin select bits: I/O or touch input
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps
module touch_key_measure #(
    parameter int modules = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [modules*4-1:0] key_osc_in,
    input wire logic [modules-1:0] ref_osc_in,
    output logic [modules*4-1:0] pin_touch_mode,
    output logic [modules*2-1:0] key_mux_select,
    output logic [modules*3-1:0] osc_frequency_code,
    output logic [modules-1:0] hopping_hw_control,
    output logic [modules-1:0] multi_frequency_enable,
    output logic [modules-1:0] filter_enable,
    output logic [modules*10-1:0] ref_capacitor,
    output logic [modules-1:0] reference_osc_run,
    output logic [modules-1:0] key_osc_run,
    output logic [1:0] osc_frequency_field,
    output logic touch_interrupt_request_flag
);
    import touch_key_pkg::*;

    // Elaboration checks: the decode below assumes these shapes
    initial begin
        if (modules < 2 || modules > 3) begin
            $error("modules must be 2 or 3");
        end
        if (slot_prescale != (1 << slot_prescale_bits)) begin
            $error("slot prescaler width does not match its count");
        end
        if (slot_base != 256) begin
            $error("slot base must match the 8-bit slot timer");
        end
        // Module decode uses the low three index bits as sub-register
        if (int'(idx_module_stride) != 8) begin
            $error("module register stride must be eight");
        end
        if (int'(idx_reference_count_high) >= int'(idx_module_base)) begin
            $error("common registers overlap module registers");
        end
        if (int'(idx_module_base) + modules * int'(idx_module_stride) > 256) begin
            $error("module registers exceed the address window");
        end
        if (slot_sysclk_div != 2'h3) begin
            $error("slot clock divider must give sysclk/4");
        end
        if (count_max != 16'hffff) begin
            $error("counters are sixteen bits wide");
        end
    end

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] time_slot_timer;
        logic [7:0] touch_control;
        logic [7:0] touch_osc_frequency;
        logic [15:0] ref_count;
        logic [2:0] sys_div;
        logic window;
        logic start_prev;
        logic irq;
        logic [modules-1:0] slot_done;
        logic [modules-1:0] key_run;
        logic [modules-1:0] ref_run;
        logic [modules*4-1:0] key_pin_s1;
        logic [modules*4-1:0] key_pin_s2;
        logic [modules-1:0] ref_pin_s1;
        logic [modules-1:0] ref_pin_s2;
        logic [modules-1:0][2:0] hop_code;
        logic [modules-1:0][2:0] freq_code;
        module_regs_t [modules-1:0] mregs;
        module_meas_t [modules-1:0] meas;
    } state_t;

    state_t r;
    state_t next_r;

    always_comb begin
        logic [7:0] idx;
        logic [7:0] rel;
        logic [7:0] wbyte;
        logic [7:0] rbyte;
        logic wr;
        logic hit;
        logic start;
        logic start_rise;
        logic ref_tick;
        logic sys4_tick;
        logic cf_ovf;
        logic ref_ovf;
        logic slot_ovf;
        logic [modules-1:0] own_ovf;
        logic [modules-1:0] slot_tick;
        logic key_rise;
        logic ref_rise;
        logic [1:0] mux;
        logic access;
        int m;
        idx = paddr[9:2];
        rel = 8'h00;
        wbyte = pwdata[7:0];
        rbyte = reset_byte;
        // An access acts only while pready is low, so a held access phase writes on every other cycle
        access = psel && penable && !r.pready;
        wr = access && pwrite && pstrb[0];
        hit = 1'b0;
        start = r.touch_control[bit_start];
        start_rise = start && !r.start_prev;
        cf_ovf = 1'b0;
        ref_ovf = 1'b0;
        slot_ovf = 1'b0;
        own_ovf = '0;
        slot_tick = '0;
        key_rise = 1'b0;
        ref_rise = 1'b0;
        mux = 2'h0;
        m = 0;
        next_r = r;
        next_r.start_prev = start;
        next_r.irq = 1'b0;
        next_r.sys_div = 3'(r.sys_div + 3'h1);
        // Oscillator pins are asynchronous: two flops before the key mux
        next_r.key_pin_s1 = key_osc_in;
        next_r.key_pin_s2 = r.key_pin_s1;
        next_r.ref_pin_s1 = ref_osc_in;
        next_r.ref_pin_s2 = r.ref_pin_s1;
        // Reference counter clock enable
        case (r.touch_control[1:0])
            2'h0: ref_tick = 1'b1;
            2'h1: ref_tick = r.sys_div[0];
            2'h2: ref_tick = &r.sys_div[1:0];
            default: ref_tick = &r.sys_div;
        endcase
        sys4_tick = (r.sys_div[1:0] == slot_sysclk_div);

        // Measurement per module
        for (m = 0; m < modules; m++) begin
            mux = r.mregs[m].control_mux_freq[7:6];
            next_r.meas[m].key_sync1 = {r.ref_pin_s2[m], r.key_pin_s2[m*4+int'(mux)]};
            next_r.meas[m].key_sync2 = r.meas[m].key_sync1;
            next_r.meas[m].key_prev = r.meas[m].key_sync2;
            key_rise = r.meas[m].key_sync2[0] && !r.meas[m].key_prev[0]
                && r.mregs[m].control_osc_pins[bit_key_osc_enable];
            ref_rise = r.meas[m].key_sync2[1] && !r.meas[m].key_prev[1]
                && r.mregs[m].control_osc_pins[bit_reference_osc_enable];
            // Slot clock source
            slot_tick[m] = r.mregs[m].control_osc_pins[bit_slot_clock_select]
                ? sys4_tick : ref_rise;
            if (r.window) begin
                if (key_rise) begin
                    next_r.meas[m].cf_count = 16'(r.meas[m].cf_count + 16'h1);
                    if (r.meas[m].cf_count == count_max) begin
                        cf_ovf = 1'b1;
                    end
                end
                if (slot_tick[m] && !r.slot_done[m]) begin
                    next_r.meas[m].prescale =
                        slot_prescale_bits'(r.meas[m].prescale + 1'b1);
                    if (&r.meas[m].prescale) begin
                        next_r.meas[m].timer = 8'(r.meas[m].timer + 8'h1);
                        own_ovf[m] = &r.meas[m].timer;
                    end
                end
            end
        end
        // Shared or per-module slot overflow
        if (r.touch_control[bit_shared_slot]) begin
            slot_ovf = own_ovf[0];
        end else begin
            // Modules on separate reference oscillators finish apart
            slot_ovf = &(r.slot_done | own_ovf);
        end
        next_r.slot_done = r.slot_done | own_ovf;
        if (r.window && ref_tick) begin
            next_r.ref_count = 16'(r.ref_count + 16'h1);
            ref_ovf = (r.ref_count == count_max);
        end

        // APB access
        next_r.pready = access;
        next_r.pslverr = 1'b0;
        if (idx < idx_module_base) begin
            hit = idx <= idx_reference_count_high;
            case (idx)
                idx_time_slot_timer: rbyte = r.time_slot_timer;
                idx_touch_control: rbyte = r.touch_control;
                idx_touch_osc_frequency: rbyte = r.touch_osc_frequency;
                idx_reference_count_low: rbyte = r.ref_count[7:0];
                idx_reference_count_high: rbyte = r.ref_count[15:8];
                default: rbyte = reset_byte;
            endcase
            if (wr) begin
                case (idx)
                    idx_time_slot_timer: next_r.time_slot_timer = wbyte;
                    idx_touch_control: begin
                        // Flags: zero clears, one
                        next_r.touch_control = wbyte & touch_control_mask;
                        next_r.touch_control[bit_slot_ovf] =
                            wbyte[bit_slot_ovf] & r.touch_control[bit_slot_ovf];
                        next_r.touch_control[bit_cf_ovf] =
                            wbyte[bit_cf_ovf] & r.touch_control[bit_cf_ovf];
                        next_r.touch_control[bit_ref_ovf] =
                            wbyte[bit_ref_ovf] & r.touch_control[bit_ref_ovf];
                    end
                    idx_touch_osc_frequency:
                        next_r.touch_osc_frequency = wbyte & touch_osc_frequency_mask;
                    default: ;
                endcase
            end
        end else begin
            rel = 8'(idx - idx_module_base);
            for (m = 0; m < modules; m++) begin
                if (rel[7:3] == 5'(m)) begin
                    hit = rel[2:0] <= sub_control_osc_pins;
                    case (rel[2:0])
                        sub_cf_count_low: rbyte = r.meas[m].cf_count[7:0];
                        sub_cf_count_high: rbyte = r.meas[m].cf_count[15:8];
                        sub_ref_capacitor_low: rbyte = r.mregs[m].ref_capacitor_low;
                        sub_ref_capacitor_high: rbyte = r.mregs[m].ref_capacitor_high;
                        sub_control_mux_freq: rbyte = r.mregs[m].control_mux_freq;
                        sub_control_osc_pins: rbyte = r.mregs[m].control_osc_pins;
                        default: rbyte = reset_byte;
                    endcase
                    if (wr) begin
                        case (rel[2:0])
                            sub_ref_capacitor_low:
                                next_r.mregs[m].ref_capacitor_low = wbyte;
                            sub_ref_capacitor_high:
                                next_r.mregs[m].ref_capacitor_high =
                                    wbyte & ref_capacitor_high_mask;
                            sub_control_mux_freq:
                                next_r.mregs[m].control_mux_freq = wbyte;
                            sub_control_osc_pins:
                                next_r.mregs[m].control_osc_pins =
                                    wbyte & control_osc_pins_mask;
                            default: ;
                        endcase
                    end
                end
            end
        end
        if (access) begin
            next_r.prdata = {24'h0, rbyte};
            next_r.pslverr = !hit;
        end

        // Window control; hardware set wins over software clear
        if (cf_ovf) begin
            next_r.touch_control[bit_cf_ovf] = 1'b1;
        end
        if (ref_ovf) begin
            next_r.touch_control[bit_ref_ovf] = 1'b1;
        end
        if (!start) begin
            next_r.window = 1'b0;
            next_r.slot_done = '0;
            next_r.ref_count = 16'h0;
            for (m = 0; m < modules; m++) begin
                next_r.meas[m].cf_count = 16'h0;
                next_r.meas[m].prescale = '0;
            end
        end else if (start_rise) begin
            next_r.window = 1'b1;
            next_r.slot_done = '0;
            for (m = 0; m < modules; m++) begin
                next_r.meas[m].timer = r.time_slot_timer;
            end
        end else if (r.window && slot_ovf) begin
            next_r.window = 1'b0;
            next_r.touch_control[bit_slot_ovf] = 1'b1;
            next_r.irq = 1'b1;
        end

        // Run enables and frequency codes are registered for the pads
        for (m = 0; m < modules; m++) begin
            next_r.key_run[m] = next_r.window
                && next_r.mregs[m].control_osc_pins[bit_key_osc_enable];
            next_r.ref_run[m] = next_r.window
                && next_r.mregs[m].control_osc_pins[bit_reference_osc_enable];
            // Hardware hopping steps to the next code after each window
            if (r.window && !next_r.window) begin
                next_r.hop_code[m] = 3'(r.hop_code[m] + 3'h1);
            end
            if (next_r.mregs[m].control_mux_freq[3]) begin
                next_r.freq_code[m] = next_r.hop_code[m];
            end else begin
                next_r.freq_code[m] = next_r.mregs[m].control_mux_freq[2:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from state flops
    always_comb begin
        int m;
        prdata = r.prdata;
        pready = r.pready;
        pslverr = r.pslverr;
        osc_frequency_field = r.touch_osc_frequency[1:0];
        touch_interrupt_request_flag = r.irq;
        for (m = 0; m < modules; m++) begin
            pin_touch_mode[m*4 +: 4] = r.mregs[m].control_osc_pins[3:0];
            key_mux_select[m*2 +: 2] = r.mregs[m].control_mux_freq[7:6];
            osc_frequency_code[m*3 +: 3] = r.freq_code[m];
            hopping_hw_control[m] = r.mregs[m].control_mux_freq[3];
            multi_frequency_enable[m] = r.mregs[m].control_mux_freq[5];
            filter_enable[m] = r.mregs[m].control_mux_freq[4];
            ref_capacitor[m*10 +: 10] =
                {r.mregs[m].ref_capacitor_high[1:0], r.mregs[m].ref_capacitor_low};
            // Oscillators stop when the window closes
            reference_osc_run[m] = r.ref_run[m];
            key_osc_run[m] = r.key_run[m];
        end
    end

endmodule // touch_key_measure

// >>> verif/touch_pad_model.sv
`timescale 1ns/10ps
module touch_pad_model #(
    parameter int modules = 3
) (
    input wire logic [modules-1:0] key_osc_run,
    input wire logic [modules-1:0] reference_osc_run,
    output logic [modules*4-1:0] key_osc_in,
    output logic [modules-1:0] ref_osc_in
);
    initial key_osc_in = '0;
    initial ref_osc_in = '0;
    // Oscillators run only while enabled, then stand still low
    always #20 begin
        for (int m = 0; m < modules; m++) begin
            key_osc_in[4*m+:4] <= key_osc_run[m] ? ~key_osc_in[4*m+:4] : 4'h0;
            ref_osc_in[m] <= reference_osc_run[m] ? ~ref_osc_in[m] : 1'b0;
        end
    end
endmodule // touch_pad_model

// >>> verif/touch_key_monitor.sv
`timescale 1ns/10ps
module touch_key_monitor import touch_key_pkg::*; #(
    parameter int modules = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [modules*4-1:0] pin_touch_mode,
    input wire logic [modules*2-1:0] key_mux_select,
    input wire logic [modules*3-1:0] osc_frequency_code,
    input wire logic [modules-1:0] hopping_hw_control,
    input wire logic [modules-1:0] multi_frequency_enable,
    input wire logic [modules-1:0] filter_enable,
    input wire logic [modules*10-1:0] ref_capacitor,
    input wire logic [modules-1:0] reference_osc_run,
    input wire logic [modules-1:0] key_osc_run,
    input wire logic [1:0] osc_frequency_field,
    input wire logic touch_interrupt_request_flag
);
    localparam logic [11:0] ad_mux = {2'h0, idx_module_base + 8'(sub_control_mux_freq), 2'h0};
    localparam logic [11:0] ad_pins = {2'h0, idx_module_base + 8'(sub_control_osc_pins), 2'h0};
    localparam logic [11:0] ad_cap = {2'h0, idx_module_base + 8'(sub_ref_capacitor_low), 2'h0};
    localparam logic [11:0] ad_freq = {2'h0, idx_touch_osc_frequency, 2'h0};
    logic wr;
    assign wr = psel && penable && pready && pwrite && pstrb[0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_mux_write: assert property (wr && paddr == ad_mux |=>
        key_mux_select[1:0] == $past(pwdata[7:6])) else $error("key mux not updated");
    a_soft_freq_write: assert property (wr && paddr == ad_mux |=>
        hopping_hw_control[0] == $past(pwdata[3])
        && ($past(pwdata[3]) || osc_frequency_code[2:0] == $past(pwdata[2:0])))
        else $error("frequency control not updated");
    a_mf_filter_write: assert property (wr && paddr == ad_mux |=>
        multi_frequency_enable[0] == $past(pwdata[5]) && filter_enable[0] == $past(pwdata[4]))
        else $error("multi frequency or filter not updated");
    a_pin_mode_write: assert property (wr && paddr == ad_pins |=>
        pin_touch_mode[3:0] == $past(pwdata[3:0])) else $error("pin mode not updated");
    a_freq_field_write: assert property (wr && paddr == ad_freq |=>
        osc_frequency_field == $past(pwdata[1:0])) else $error("osc frequency not updated");
    a_cap_low_write: assert property (wr && paddr == ad_cap |=>
        ref_capacitor[7:0] == $past(pwdata[7:0])) else $error("capacitor low not updated");
    a_irq_one_cycle: assert property (touch_interrupt_request_flag |=>
        !touch_interrupt_request_flag) else $error("interrupt pulse too long");
    a_osc_stop_slot: assert property (touch_interrupt_request_flag |=>
        key_osc_run == '0 && reference_osc_run == '0) else $error("oscillators run after slot end");
    c_slot_end: cover property (touch_interrupt_request_flag);
    c_unmapped: cover property (pslverr && pready);
    c_pins_write: cover property (wr && paddr == ad_pins);
endmodule // touch_key_monitor

bind touch_key_measure touch_key_monitor #(.modules(modules)) touch_key_monitor_i (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr,
    .pin_touch_mode, .key_mux_select, .osc_frequency_code, .hopping_hw_control,
    .multi_frequency_enable, .filter_enable, .ref_capacitor, .reference_osc_run,
    .key_osc_run, .osc_frequency_field, .touch_interrupt_request_flag);

// >>> verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import touch_key_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr, touch_interrupt_request_flag;
    logic [11:0] key_osc_in, pin_touch_mode;
    logic [2:0] ref_osc_in, hopping_hw_control, multi_frequency_enable, filter_enable;
    logic [2:0] reference_osc_run, key_osc_run;
    logic [5:0] key_mux_select;
    logic [8:0] osc_frequency_code;
    logic [29:0] ref_capacitor;
    logic [1:0] osc_frequency_field;
    int fail_count = 0, comparisons = 0;
    always #2.5 pclk = ~pclk;
    touch_key_measure #(.modules(3)) touch_key_measure_i (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .key_osc_in, .ref_osc_in,
        .pin_touch_mode, .key_mux_select, .osc_frequency_code, .hopping_hw_control,
        .multi_frequency_enable, .filter_enable, .ref_capacitor, .reference_osc_run,
        .key_osc_run, .osc_frequency_field, .touch_interrupt_request_flag);
    touch_pad_model #(.modules(3)) touch_pad_model_i (.key_osc_run, .reference_osc_run,
        .key_osc_in, .ref_osc_in);
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d,
        output logic [7:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail_count++;
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] q;
        logic e;
        apb(1'b1, i, d, q, e);
    endtask
    task automatic rc(input logic [7:0] i, input logic [7:0] x);
        logic [7:0] q;
        logic e;
        apb(1'b0, i, 8'h00, q, e);
        chk8(q, x);
    endtask
    function automatic logic [7:0] mi(input int m, input logic [2:0] s);
        return idx_module_base + idx_module_stride * 8'(m) + 8'(s);
    endfunction
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        conclude();
    end
    initial begin
        logic [7:0] q;
        logic e;
        logic [2:0] c;
        int t;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rc(8'(i), 8'h00);
        for (int m = 0; m < 18; m++) rc(mi(m / 6, 3'(m % 6)), 8'h00);
        $display("test reset values done");
        for (int m = 0; m < 3; m++) begin
            for (int s = 0; s < 6; s++) wr(mi(m, 3'(s)), 8'hff);
            rc(mi(m, sub_cf_count_low), 8'h00);
            rc(mi(m, sub_ref_capacitor_high), 8'h03);
            rc(mi(m, sub_control_osc_pins), 8'hbf);
            chk8(8'(ref_capacitor[10*m+:10] >> 2), 8'hff);
        end
        chk8(8'(pin_touch_mode >> 4), 8'hff);
        wr(idx_touch_osc_frequency, 8'hff);
        rc(idx_touch_osc_frequency, 8'h03);
        apb(1'b0, 8'h05, 8'h00, q, e);
        chk1(e, 1'b1);
        chk8(q, 8'h00);
        pstrb <= 4'h0;
        wr(idx_time_slot_timer, 8'h5a);
        pstrb <= 4'hf;
        rc(idx_time_slot_timer, 8'h00);
        $display("test access kinds done");
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            wr(mi(1, sub_control_mux_freq), {c[1:0], c[0], c[1], 1'b0, c});
            wr(idx_touch_osc_frequency, 8'(c[1:0]));
            chk8(8'(key_mux_select[3:2]), 8'(c[1:0]));
            chk8(8'(osc_frequency_code[5:3]), 8'(c));
            chk1(multi_frequency_enable[1], c[0]);
            chk1(filter_enable[1], c[1]);
            chk1(hopping_hw_control[1], 1'b0);
            chk8(8'(osc_frequency_field), 8'(c[1:0]));
        end
        wr(mi(1, sub_control_mux_freq), 8'h08);
        chk1(hopping_hw_control[1], 1'b1);
        $display("test config fields done");
        wr(idx_time_slot_timer, 8'hfd);
        for (int dv = 0; dv < 4; dv++) begin
            wr(idx_touch_control, 8'h00);
            rc(idx_touch_control, 8'h00);
            rc(mi(2, sub_cf_count_low), 8'h00);
            rc(idx_reference_count_low, 8'h00);
            rc(idx_time_slot_timer, 8'hfd);
            wr(idx_touch_control, 8'h20 | 8'(dv) | 8'(4 * (dv % 2)));
            t = 0;
            while (touch_interrupt_request_flag !== 1'b1 && t < 2000) begin
                @(posedge pclk);
                t++;
                if (t == 100) chk8(8'(key_osc_run), 8'h07);
            end
            chk1(t > 370 && t < 395, 1'b1);
            @(posedge pclk);
            chk8(8'(key_osc_run), 8'h00);
            rc(idx_touch_control, 8'h60 | 8'(dv) | 8'(4 * (dv % 2)));
            rc(idx_reference_count_high, 8'(384 >> (dv + 8)));
            apb(1'b0, idx_reference_count_low, 8'h00, q, e);
            t = (384 >> dv) % 256;
            chk1(int'(q) > t - 6 && int'(q) < t + 6, 1'b1);
            apb(1'b0, mi(2, sub_cf_count_low), 8'h00, q, e);
            chk1(q > 8'd40 && q < 8'd56, 1'b1);
            $display("test window divider %0d done", dv);
        end
        chk8(8'(osc_frequency_code[5:3]), 8'h04);
        conclude();
    end
endmodule // tb_top
